// ===== hw/ufc_regs.svh
// Register map, field positions and timing constants of the UART FIFO block.
// Assumes inclusion by bare name from every file that decodes registers.
`ifndef UFC_REGS_SVH
`define UFC_REGS_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define UFC_A_DATA      4'h0
`define UFC_A_IER       4'h1
`define UFC_A_IIR       4'h2
`define UFC_A_LCR       4'h3
`define UFC_A_MCR       4'h4
`define UFC_A_LSR       4'h5
`define UFC_A_RSV       4'h6
`define UFC_A_SCR       4'h7
`define UFC_A_DLL       4'h8
`define UFC_A_DLM       4'h9
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UFC_FCR_EN      0
`define UFC_FCR_RXRST   1
`define UFC_FCR_TXRST   2
`define UFC_IER_RDA     0
`define UFC_IER_HOLDING_EMPTY_IRQ    1
`define UFC_IER_LS      2
`define UFC_LCR_STB     2
`define UFC_LCR_PEN     3
`define UFC_LCR_DIVISOR_ACCESS_SELECT    7
// ----------------------------------------------------------------------
// Identification codes and trigger levels
// ----------------------------------------------------------------------
`define UFC_IIR_NONE    4'h1
`define UFC_IIR_LS      4'h6
`define UFC_IIR_RDA     4'h4
`define UFC_IIR_TO      4'hC
`define UFC_IIR_HOLDING_EMPTY_IRQ    4'h2
`define UFC_TRIG_00     5'h01
`define UFC_TRIG_01     5'h04
`define UFC_TRIG_10     5'h08
`define UFC_TRIG_11     5'h0E
// ----------------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------------
`define UFC_DEPTH       5'h10
`define UFC_AW          4
`define UFC_CHAR_BASE   4'h7
`define UFC_TICKS_BIT   11'h010
`define UFC_TO_CHARS    11'h004
`endif

// ===== hw/ufc_pkg.sv
// Types shared by the UART FIFO block.
// Assumes nothing of its surroundings.
`default_nettype none
package ufc_pkg;
  typedef enum logic [1:0] {TH_IDLE, TH_WAIT, TH_PEND} ufc_holding_empty_irq_type;
  typedef logic [3:0] ufc_iir_type;
  typedef logic [4:0] ufc_cnt_type;
endpackage
`default_nettype wire

// ===== hw/ufc_fifo.sv
// Sixteen-deep FIFO with registered head output.
// Assumes pops spaced by two cycles when the head is read directly.
`include "ufc_regs.svh"
`default_nettype none
module ufc_fifo #(parameter int W = 8) (
  input  wire logic           clk,   // System clock
  input  wire logic           rst,   // Synchronous reset
  input  wire logic           clr,   // Discard all contents
  input  wire logic           push,  // Write din
  input  wire logic [W-1:0]   din,   // Write data
  input  wire logic           pop,   // Drop head
  output logic      [W-1:0]   dout,  // Registered head word
  output var ufc_pkg::ufc_cnt_type count  // Fill level
);
  import ufc_pkg::*;
  logic [W-1:0]       mem [0:15];
  logic [`UFC_AW-1:0] wp_q;
  logic [`UFC_AW-1:0] rp_q;
  ufc_cnt_type        cnt_q;
  logic [W-1:0]       dout_q;
  wire                do_push = push && (cnt_q != `UFC_DEPTH) && !clr;
  wire                do_pop  = pop && (cnt_q != 5'h00) && !clr;
  // Pointers and counter; clear wins over traffic
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      wp_q  <= 4'h0;
      rp_q  <= 4'h0;
      cnt_q <= 5'h00;
    end else begin
      wp_q  <= wp_q + {3'h0, do_push};
      rp_q  <= rp_q + {3'h0, do_pop};
      cnt_q <= cnt_q + {4'h0, do_push} - {4'h0, do_pop};
    end
  end
  // Storage and registered head
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp_q] <= din;
    end
    dout_q <= mem[rp_q];
  end
  assign dout  = dout_q;
  assign count = cnt_q;
endmodule
`default_nettype wire

// ===== hw/ufc_top.sv
// UART FIFO control, interrupt identification and line status logic.
// Assumes receive/transmit shifters outside on SYS_CLK and a baud clock pin.
`include "ufc_regs.svh"
`default_nettype none
module ufc_top (
  input  wire logic        SYS_CLK,   // 10 MHz system clock
  input  wire logic        RESET,     // Synchronous reset, active high
  input  wire logic [3:0]  ADDR,      // Register subbank address
  input  wire logic        WR,        // Register write strobe
  input  wire logic        RD,        // Register read strobe
  input  wire logic [15:0] WDATA,     // Write data
  output logic      [15:0] RDATA,     // Read data, one cycle after RD
  input  wire logic        RCLK,      // Receive baud clock pin, 16x
  input  wire logic        RX_VALID,  // Character from receive shifter
  input  wire logic [7:0]  RX_DATA,   // Received character
  input  wire logic [2:0]  RX_ERR,    // Break, framing, parity flags
  output logic      [7:0]  TX_DATA,   // Character to transmit shifter
  output logic             TX_VALID,  // TX_DATA holds a character
  input  wire logic        TX_READY,  // Transmit shifter takes TX_DATA
  input  wire logic        TX_BUSY,   // Transmit shifter still shifting
  output logic             INTRPT     // Interrupt request, active high
);
  import ufc_pkg::*;
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic         rclk_s1_q, rclk_s2_q, rclk_s3_q;
  logic [3:0]   ier_q;
  logic [7:0]   lcr_q, scr_q, dll_q, dlm_q;
  logic [4:0]   mcr_q;
  logic         fen_q;
  logic [1:0]   trig_q;
  logic [3:0]   lsr_err_q, lsr_err_d;
  ufc_cnt_type  err_cnt_q, rx_cnt, tx_cnt;
  logic [10:0]  to_q, th_cnt_q;
  ufc_holding_empty_irq_type th_q, th_d;
  logic         two_q, ier_holding_empty_irq_q;
  logic         infl_q, v0_q, v1_q, v0_d, v1_d;
  logic [7:0]   b0_q, b1_q, b0_d, b1_d;
  logic [10:0]  rx_dout;
  logic [7:0]   tx_dout;
  logic [15:0]  rdata_q, rdata_d;
  logic         intr_q;
  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  wire       tick    = rclk_s2_q && !rclk_s3_q;      // Baud clock rising edge
  wire       divisor_access_select    = lcr_q[`UFC_LCR_DIVISOR_ACCESS_SELECT];
  wire       a_data  = ADDR == `UFC_A_DATA;
  wire       wr_thr  = WR && a_data && !divisor_access_select;
  wire       rd_rbr  = RD && a_data && !divisor_access_select;
  wire       wr_dll  = WR && ((a_data && divisor_access_select) || ADDR == `UFC_A_DLL);
  wire       wr_ier  = WR && ADDR == `UFC_A_IER && !divisor_access_select;
  wire       wr_dlm  = WR && ((ADDR == `UFC_A_IER && divisor_access_select) || ADDR == `UFC_A_DLM);
  wire       wr_fcr  = WR && ADDR == `UFC_A_IIR;
  wire       rd_iir  = RD && ADDR == `UFC_A_IIR;
  wire       wr_lcr  = WR && ADDR == `UFC_A_LCR;
  wire       wr_mcr  = WR && ADDR == `UFC_A_MCR;
  wire       wr_scr  = WR && ADDR == `UFC_A_SCR;
  wire       rd_lsr  = RD && ADDR == `UFC_A_LSR;
  wire       fcr_on  = WDATA[`UFC_FCR_EN];
  wire       fen_chg = wr_fcr && (fcr_on != fen_q);
  wire       rx_clr  = fen_chg || (wr_fcr && fcr_on && WDATA[`UFC_FCR_RXRST]);
  wire       tx_clr  = fen_chg || (wr_fcr && fcr_on && WDATA[`UFC_FCR_TXRST]);
  // ----------------------------------------------------------------------
  // FIFO traffic; single holding location when FIFOs are off
  // ----------------------------------------------------------------------
  wire [4:0] lim       = fen_q ? `UFC_DEPTH : 5'h01;
  wire       rx_room   = rx_cnt < lim;
  wire       rx_push   = RX_VALID && rx_room;
  wire       overrun   = RX_VALID && !rx_room;
  wire       rx_pop    = rd_rbr && rx_cnt != 5'h00;
  wire       tx_push   = wr_thr && tx_cnt < lim;
  wire [1:0] used      = {1'b0, v0_q} + {1'b0, v1_q} + {1'b0, infl_q};
  wire       tx_pop    = tx_cnt != 5'h00 && used < 2'h2 && !tx_clr;
  wire       tx_evt    = (tx_pop && tx_cnt == 5'h01 && !tx_push) || tx_clr;
  wire       rx_has    = rx_cnt != 5'h00;
  wire       head_err  = rx_has && |rx_dout[10:8];
  wire       push_err  = rx_push && |RX_ERR;
  // ----------------------------------------------------------------------
  // Character timing from line format
  // ----------------------------------------------------------------------
  wire       stb       = lcr_q[`UFC_LCR_STB];
  wire [3:0] char_bits = `UFC_CHAR_BASE + {2'h0, lcr_q[1:0]}
                         + {3'h0, lcr_q[`UFC_LCR_PEN]} + {3'h0, stb};
  wire [10:0] to_lim   = {7'h00, char_bits} * `UFC_TICKS_BIT * `UFC_TO_CHARS;
  wire [10:0] th_lim   = {7'h00, char_bits - 4'h1} * `UFC_TICKS_BIT;
  wire       to_hit    = to_q >= to_lim;
  // ----------------------------------------------------------------------
  // Interrupt sources and identification
  // ----------------------------------------------------------------------
  wire [4:0] trig_lvl  = trig_q == 2'h0 ? `UFC_TRIG_00 :
                         trig_q == 2'h1 ? `UFC_TRIG_01 :
                         trig_q == 2'h2 ? `UFC_TRIG_10 : `UFC_TRIG_11;
  wire       rda       = ier_q[`UFC_IER_RDA] &&
                         (fen_q ? rx_cnt >= trig_lvl : rx_has);
  wire       to_irq    = fen_q && ier_q[`UFC_IER_RDA] && rx_has && to_hit;
  wire       ls_irq    = ier_q[`UFC_IER_LS] && |lsr_err_q;
  wire       holding_empty_irq_irq  = ier_q[`UFC_IER_HOLDING_EMPTY_IRQ] && th_q == TH_PEND;
  wire ufc_iir_type iir_id = ls_irq   ? `UFC_IIR_LS :
                             to_irq   ? `UFC_IIR_TO :
                             rda      ? `UFC_IIR_RDA :
                             holding_empty_irq_irq ? `UFC_IIR_HOLDING_EMPTY_IRQ : `UFC_IIR_NONE;
  wire [7:0] iir_val   = {fen_q, fen_q, 2'h0, iir_id};
  wire       hold_emp  = tx_cnt == 5'h00;
  wire       tx_idle   = hold_emp && !v0_q && !v1_q && !infl_q && !TX_BUSY;
  wire [7:0] lsr_val   = {fen_q && err_cnt_q != 5'h00, tx_idle, hold_emp,
                          lsr_err_q, rx_has};
  wire       thr_clr   = wr_thr || (rd_iir && iir_id == `UFC_IIR_HOLDING_EMPTY_IRQ);
  wire       holding_empty_irq_rise = wr_ier && WDATA[`UFC_IER_HOLDING_EMPTY_IRQ] && !ier_holding_empty_irq_q && hold_emp;
  // ----------------------------------------------------------------------
  // Receive and transmit FIFOs
  // ----------------------------------------------------------------------
  ufc_fifo #(.W(11)) u_rx (
    .clk   (SYS_CLK),
    .rst   (RESET),
    .clr   (rx_clr),
    .push  (rx_push),
    .din   ({RX_ERR, RX_DATA}),
    .pop   (rx_pop),
    .dout  (rx_dout),
    .count (rx_cnt)
  );
  ufc_fifo #(.W(8)) u_tx (
    .clk   (SYS_CLK),
    .rst   (RESET),
    .clr   (tx_clr),
    .push  (tx_push),
    .din   (WDATA[7:0]),
    .pop   (tx_pop),
    .dout  (tx_dout),
    .count (tx_cnt)
  );
  // Baud clock pin synchroniser
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rclk_s1_q <= 1'b0;
      rclk_s2_q <= 1'b0;
      rclk_s3_q <= 1'b0;
    end else begin
      rclk_s1_q <= RCLK;
      rclk_s2_q <= rclk_s1_q;
      rclk_s3_q <= rclk_s2_q;
    end
  end
  // Host-written control registers
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ier_q  <= 4'h0;
      lcr_q  <= 8'h00;
      mcr_q  <= 5'h00;
      fen_q  <= 1'b0;
      trig_q <= 2'h0;
    end else begin
      if (wr_ier) ier_q <= WDATA[3:0];
      if (wr_lcr) lcr_q <= WDATA[7:0];
      if (wr_mcr) mcr_q <= WDATA[4:0];
      if (wr_fcr) fen_q <= fcr_on;
      if (wr_fcr && fcr_on) trig_q <= WDATA[7:6];
    end
  end
  // Registers untouched by reset
  always_ff @(posedge SYS_CLK) begin
    if (wr_scr) scr_q <= WDATA[7:0];
    if (wr_dll) dll_q <= WDATA[7:0];
    if (wr_dlm) dlm_q <= WDATA[7:0];
  end
  // Line status error flags; a new error wins over the clearing read
  assign lsr_err_d = (rd_lsr ? 4'h0 : lsr_err_q) |
                     {push_err && RX_ERR[2], push_err && RX_ERR[1],
                      push_err && RX_ERR[0], overrun};
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      lsr_err_q <= 4'h0;
      err_cnt_q <= 5'h00;
    end else begin
      lsr_err_q <= lsr_err_d;
      err_cnt_q <= rx_clr ? 5'h00 :
                   err_cnt_q + {4'h0, push_err} - {4'h0, rx_pop && head_err};
    end
  end
  // Character time-out timer
  always_ff @(posedge SYS_CLK) begin
    if (RESET || rx_pop || !rx_has || (rx_push && !to_hit)) begin
      to_q <= 11'h000;
    end else if (tick && !to_hit) begin
      to_q <= to_q + 11'h001;
    end
  end
  // Transmit-empty pending state
  always_comb begin
    th_d = th_q;
    case (th_q)
      TH_IDLE: th_d = TH_IDLE;
      TH_WAIT: th_d = tx_push ? TH_IDLE : (th_cnt_q >= th_lim ? TH_PEND : TH_WAIT);
      TH_PEND: th_d = thr_clr ? TH_IDLE : TH_PEND;
      default: th_d = TH_IDLE;
    endcase
    if (fen_chg || holding_empty_irq_rise) begin
      th_d = TH_PEND;
    end else if (tx_evt) begin
      th_d = (two_q || !fen_q) ? TH_PEND : TH_WAIT;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      th_q       <= TH_IDLE;
      th_cnt_q   <= 11'h000;
      two_q      <= 1'b0;
      ier_holding_empty_irq_q <= 1'b0;
    end else begin
      th_q       <= th_d;
      th_cnt_q   <= (th_q != TH_WAIT) ? 11'h000 : th_cnt_q + {10'h000, tick};
      two_q      <= tx_evt ? 1'b0 : (two_q || tx_cnt >= 5'h02);
      ier_holding_empty_irq_q <= wr_ier ? WDATA[`UFC_IER_HOLDING_EMPTY_IRQ] : ier_q[`UFC_IER_HOLDING_EMPTY_IRQ];
    end
  end
  // Two-entry buffer toward the transmit shifter
  always_comb begin
    v0_d = v0_q;
    v1_d = v1_q;
    b0_d = b0_q;
    b1_d = b1_q;
    if (v0_q && TX_READY) begin
      v0_d = v1_q;
      b0_d = b1_q;
      v1_d = 1'b0;
    end
    if (infl_q && !v0_d) begin
      v0_d = 1'b1;
      b0_d = tx_dout;
    end else if (infl_q) begin
      v1_d = 1'b1;
      b1_d = tx_dout;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      infl_q <= 1'b0;
      v0_q   <= 1'b0;
      v1_q   <= 1'b0;
      b0_q   <= 8'h00;
      b1_q   <= 8'h00;
    end else begin
      infl_q <= tx_pop;
      v0_q   <= v0_d;
      v1_q   <= v1_d;
      b0_q   <= b0_d;
      b1_q   <= b1_d;
    end
  end
  // Read data selection
  always_comb begin
    rdata_d = 16'h0000;
    case (ADDR)
      `UFC_A_DATA: rdata_d = {8'h00, divisor_access_select ? dll_q : rx_dout[7:0]};
      `UFC_A_IER:  rdata_d = {8'h00, divisor_access_select ? dlm_q : {4'h0, ier_q}};
      `UFC_A_IIR:  rdata_d = {8'h00, iir_val};
      `UFC_A_LCR:  rdata_d = {8'h00, lcr_q};
      `UFC_A_MCR:  rdata_d = {11'h000, mcr_q};
      `UFC_A_LSR:  rdata_d = {8'h00, lsr_val};
      `UFC_A_SCR:  rdata_d = {8'h00, scr_q};
      `UFC_A_DLL:  rdata_d = {8'h00, dll_q};
      `UFC_A_DLM:  rdata_d = {8'h00, dlm_q};
      default:     rdata_d = 16'h0000;
    endcase
  end
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rdata_q <= 16'h0000;
      intr_q  <= 1'b0;
    end else begin
      if (RD) rdata_q <= rdata_d;
      intr_q <= iir_id != `UFC_IIR_NONE;
    end
  end
  assign RDATA    = rdata_q;
  assign INTRPT   = intr_q;
  assign TX_DATA  = b0_q;
  assign TX_VALID = v0_q;
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  fen_clear_a: assert property (fen_chg |=> rx_cnt == 5'h00 && tx_cnt == 5'h00)
    else $error("FIFOs not emptied on enable change");
  fcr_guard_a: assert property (wr_fcr && !fcr_on |=> $stable(trig_q))
    else $error("Trigger changed without enable bit");
  rx_reset_a: assert property (wr_fcr && fcr_on && WDATA[1] |=> rx_cnt == 5'h00)
    else $error("Receive FIFO not reset");
  trig_map_a: assert property (fen_q && trig_q == 2'h2 && ier_q[0] && rx_cnt == 5'h07
                               |-> !rda)
    else $error("Trigger of eight fired at seven");
  ls_prio_a: assert property (ls_irq |-> iir_id == `UFC_IIR_LS)
    else $error("Line status not top priority");
  dr_read_a: assert property (rd_lsr && rx_has |=> RDATA[0])
    else $error("Data ready missing");
  to_clear_a: assert property (to_irq && rx_pop |=> !to_irq && to_q == 11'h000)
    else $error("Time-out not cleared by read");
  holding_empty_irq_wr_a: assert property (wr_thr && !tx_evt && !fen_chg |=> th_q != TH_PEND)
    else $error("Transmit-empty not cleared by write");
  tx_accept_a: assert property (fen_q && wr_thr && tx_cnt < 5'h10 && !tx_clr && !tx_pop
                                |=> tx_cnt == $past(tx_cnt) + 5'h01)
    else $error("Transmit FIFO refused a character");
  holding_empty_irq_delay_a: assert property (tx_evt && fen_q && !two_q && !fen_chg && !holding_empty_irq_rise
                                 |=> th_q == TH_WAIT)
    else $error("Transmit-empty not delayed");
  iir_fen_a: assert property (rd_iir |=> RDATA[7:6] == {2{$past(fen_q)}})
    else $error("FIFOs-enabled bits wrong");
  intr_out_a: assert property (iir_id != `UFC_IIR_NONE |=> INTRPT)
    else $error("Interrupt output missing");
  to_fire_c: cover property (rx_has ##1 to_irq);
  holding_empty_irq_pend_c: cover property (th_q == TH_WAIT ##1 th_q == TH_PEND);
  overrun_c: cover property (overrun ##1 ls_irq);
endmodule
`default_nettype wire

// ===== tb/ufc_tx_partner.sv
// Transmit shifter model facing the UART FIFO block.
// Assumes one clock; stall holds off every handover.
`default_nettype none
module ufc_tx_partner (
  input  wire logic       clk,      // System clock
  input  wire logic       rst,      // Synchronous reset
  input  wire logic       stall,    // Refuse new words
  input  wire logic [7:0] tx_data,  // Word offered
  input  wire logic       tx_valid, // Offered word valid
  output logic            tx_ready, // Shifter takes word
  output logic            tx_busy,  // Shifter shifting
  output logic            got,      // Word taken last edge
  output logic      [7:0] got_data  // Word taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] busy_q;
  // Take a word only when idle and not stalled
  assign tx_ready = !stall && busy_q == 3'h0;
  assign tx_busy  = busy_q != 3'h0;
  // Short shift time after each handover
  always_ff @(posedge clk) begin
    got <= 1'b0;
    if (rst) begin
      busy_q <= 3'h0;
    end else if (tx_valid && tx_ready) begin
      busy_q   <= 3'h5;
      got      <= 1'b1;
      got_data <= tx_data;
    end else if (busy_q != 3'h0) begin
      busy_q <= busy_q - 3'h1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/ufc_tb_top.sv
// Self-checking bench for the UART FIFO block.
// Assumes the design, its header and the shifter model compile first.
`default_nettype none
`include "ufc_regs.svh"
module uart_fifo_interrupt_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 0, reset = 1, rclk = 0, wr = 0, rd = 0, rx_valid = 0, stall = 1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [7:0]  rx_data = 8'h00, tx_data, got_data, d;
  logic [2:0]  rx_err = 3'h0;
  logic        tx_valid, tx_ready, tx_busy, intrpt, got;
  int          fail_count = 0, samples_checked = 0;
  int          trig [4] = '{1, 4, 8, 14};
  logic [7:0]  rxq [$], txq [$];
  // Clocks; receive baud clock unrelated in phase
  always #50 sys_clk = ~sys_clk;
  always #157 rclk = ~rclk;
  ufc_top dut (.SYS_CLK(sys_clk), .RESET(reset), .ADDR(addr), .WR(wr), .RD(rd),
    .WDATA(wdata), .RDATA(rdata), .RCLK(rclk), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_ERR(rx_err), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .TX_BUSY(tx_busy), .INTRPT(intrpt));
  ufc_tx_partner shifter (.clk(sys_clk), .rst(reset), .stall(stall), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_busy(tx_busy), .got(got),
    .got_data(got_data));
  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_reg(n, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic wrap_up;
    $display("Counts: %0d checked, %0d mismatched", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] e, input string n);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    chk_reg(n, e, rdata);
    @(posedge sys_clk);
  endtask
  task automatic rx_push(input logic [7:0] v, input logic [2:0] e = 3'h0);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_data  <= v;
    rx_err   <= e;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_err   <= 3'h0;
    rxq.push_back(v);
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // Every word the shifter takes is compared with the model order
  always @(posedge sys_clk) begin
    logic [7:0] w;
    w = 8'h00;
    if (got) begin
      w = (txq.size() > 0) ? txq.pop_front() : ~got_data;
      chk_reg("tx word", {8'h00, w}, {8'h00, got_data});
    end
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'hd662));
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    reg_rd(`UFC_A_IIR, 16'h0001, "iir");
    reg_rd(`UFC_A_LSR, 16'h0060, "lsr");
    $display("Test reset done");
    reg_wr(`UFC_A_IER, 16'h0002);
    reg_wr(`UFC_A_IIR, 16'h0001);
    #1;
    chk_bit("holding_empty_irq irq", 1'b1, intrpt);
    reg_rd(`UFC_A_IIR, 16'h00C2, "iir");
    reg_rd(`UFC_A_IIR, 16'h00C1, "iir");
    reg_wr(`UFC_A_IER, 16'h0001);
    $display("Test enable done");
    // Each trigger level: fill to sixteen, then drain
    for (int c = 0; c < 4; c++) begin
      reg_wr(`UFC_A_IIR, 16'(c * 64 + 3));
      for (int i = 1; i <= 16; i++) begin
        rx_push(8'($urandom));
        chk_bit("rda irq", i >= trig[c], intrpt);
      end
      while (rxq.size() > 0) begin
        reg_rd(`UFC_A_LSR, 16'h0061, "lsr");
        reg_rd(`UFC_A_DATA, {8'h00, rxq.pop_front()}, "rbr");
        repeat (2) @(posedge sys_clk);
        #1;
        chk_bit("rda irq", rxq.size() >= trig[c], intrpt);
      end
      reg_rd(`UFC_A_LSR, 16'h0060, "lsr");
      $display("Test trigger %0d done", c);
    end
    // Receive reset, then an idle single character times out
    rx_push(8'hA5);
    reg_wr(`UFC_A_IIR, 16'h0043);
    rxq.delete();
    reg_rd(`UFC_A_LSR, 16'h0060, "lsr");
    rx_push(8'($urandom));
    repeat (1200) @(posedge sys_clk);
    #1;
    chk_bit("to irq", 1'b0, intrpt);
    for (int k = 0; k < 800 && intrpt !== 1'b1; k++) @(posedge sys_clk);
    #1;
    chk_bit("to irq", 1'b1, intrpt);
    if (intrpt !== 1'b1) wrap_up();
    reg_rd(`UFC_A_IIR, 16'h00CC, "iir");
    reg_rd(`UFC_A_DATA, {8'h00, rxq.pop_front()}, "rbr");
    repeat (2) @(posedge sys_clk);
    #1;
    chk_bit("to irq", 1'b0, intrpt);
    $display("Test timeout done");
    // Framing error on arrival: line status raised with no data interrupt pending, then clears on read
    reg_wr(`UFC_A_IER, 16'h0005);
    rx_push(8'($urandom), 3'h2);
    chk_bit("ls irq", 1'b1, intrpt);
    reg_rd(`UFC_A_IIR, 16'h00C6, "iir");
    reg_rd(`UFC_A_LSR, 16'h00E9, "lsr");
    reg_rd(`UFC_A_IIR, 16'h00C1, "iir");
    reg_rd(`UFC_A_DATA, {8'h00, rxq.pop_front()}, "rbr");
    reg_rd(`UFC_A_LSR, 16'h0060, "lsr");
    $display("Test line status done");
    // Stalled shifter: FIFO and buffer fill, extra words dropped
    reg_wr(`UFC_A_IER, 16'h0000);
    for (int i = 0; i < 20; i++) begin
      d = 8'($urandom);
      if (i < 18) txq.push_back(d);
      reg_wr(`UFC_A_DATA, {8'h00, d});
    end
    reg_rd(`UFC_A_LSR, 16'h0000, "lsr");
    stall <= 1'b0;
    for (int k = 0; k < 3000 && txq.size() > 0; k++) @(posedge sys_clk);
    chk_bit("tx drained", 1'b1, txq.size() == 0);
    repeat (20) @(posedge sys_clk);
    reg_rd(`UFC_A_LSR, 16'h0060, "lsr");
    $display("Test transmit done");
    wrap_up();
  end
endmodule
`default_nettype wire
